// ### logic/ast_uart.v
// serial transceiver with baud generator, parity, multidrop and infrared codec, apb slave
//
// The register addresses and the APB slave port were chosen for this implementation.
`default_nettype none
`include "ast_consts.vh"
module ast_uart (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        rxd,
    input  wire        cts_n,
    output reg         txd,
    output wire        irq
);
    localparam [4:0] ST_IDLE  = 5'b0_0001;
    localparam [4:0] ST_START = 5'b0_0010;
    localparam [4:0] ST_DATA  = 5'b0_0100;
    localparam [4:0] ST_EXTRA = 5'b0_1000;
    localparam [4:0] ST_STOP  = 5'b1_0000;

    // even parity bit of a byte, inverted for odd
    function par_bit;
        input [7:0] d;
        input       odd;
        begin
            par_bit = (^d) ^ odd;
        end
    endfunction

    // -------------------------------------------------------------------------
    // registers and synchronisers
    // -------------------------------------------------------------------------
    reg  [7:0]  cfg_a_r;
    reg  [7:0]  cfg_b_r;
    reg  [7:0]  baud_hi_r;
    reg  [7:0]  baud_lo_r;
    reg  [15:0] brg_cnt_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_en_r;
    reg  [7:0]  tdr_r;
    reg         tdr_full_r;
    reg  [7:0]  rdr_r;
    reg         rda_r;
    reg         fe_r;
    reg         pe_r;
    reg         ovr_r;
    reg         mark_rx_r;
    reg         rxd_s1_r;
    reg         rxd_s2_r;
    reg         cts_s1_r;
    reg         cts_s2_r;
    reg  [4:0]  ir_cnt_r;
    reg  [4:0]  tx_st_r;
    reg  [3:0]  tx_sub_r;
    reg  [2:0]  tx_bit_r;
    reg  [7:0]  tx_sh_r;
    reg         tx_x_r;
    reg  [4:0]  rx_st_r;
    reg  [3:0]  rx_sub_r;
    reg  [2:0]  rx_bit_r;
    reg  [7:0]  rx_sh_r;
    reg         rx_x_r;

    wire tx_en    = cfg_a_r[`AST_A_TX_EN];
    wire rx_en    = cfg_a_r[`AST_A_RX_EN];
    wire multi    = cfg_b_r[`AST_B_MULTIDROP];
    wire par_on   = cfg_a_r[`AST_A_PAR_EN] & ~multi;
    wire extra_on = multi | par_on;
    wire infrared = cfg_b_r[`AST_B_INFRARED];

    // -------------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------------
    wire setup   = psel & ~penable;
    wire access  = psel & penable;
    wire hit     = (paddr == `AST_OFS_DATA) | (paddr == `AST_OFS_STATUS) |
                   (paddr == `AST_OFS_CONFIG_A) | (paddr == `AST_OFS_CONFIG_B) |
                   (paddr == `AST_OFS_BAUD_HI) | (paddr == `AST_OFS_BAUD_LO) |
                   (paddr == `AST_OFS_IRQ_STAT) | (paddr == `AST_OFS_IRQ_CLR) |
                   (paddr == `AST_OFS_IRQ_EN);
    wire wr      = access & pwrite & hit;
    wire rd_data = access & ~pwrite & (paddr == `AST_OFS_DATA);
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

    // -------------------------------------------------------------------------
    // baud generator: 16 ticks per bit
    // -------------------------------------------------------------------------
    wire        tick      = (brg_cnt_r == 16'h0000);
    wire [15:0] brg_nxt   = tick ? {baud_hi_r, baud_lo_r} : brg_cnt_r - 16'h0001;
    wire        live_read = cfg_b_r[`AST_B_BAUD_CTL];
    wire [15:0] baud_view = live_read ? brg_cnt_r : {baud_hi_r, baud_lo_r};

    // -------------------------------------------------------------------------
    // line inputs, infrared decode stretches each pulse over one bit time
    // -------------------------------------------------------------------------
    wire rx_in  = infrared ? (ir_cnt_r == 5'h00) : rxd_s2_r;
    wire cts_ok = ~cfg_a_r[`AST_A_CTS_GATE] | ~cts_s2_r;

    // -------------------------------------------------------------------------
    // transmitter
    // -------------------------------------------------------------------------
    wire tx_load = tx_st_r[0] & tdr_full_r & tx_en & cts_ok;
    wire tx_end  = tick & (tx_sub_r == `AST_TICKS_BIT);
    wire tx_line = tx_st_r[1] ? 1'b0 : tx_st_r[2] ? tx_sh_r[0] :
                   tx_st_r[3] ? tx_x_r : 1'b1;
    // infrared: a short high pulse marks every zero bit, the line idles low
    wire ir_out  = ~tx_line & (tx_sub_r < `AST_IR_PULSE);

    // -------------------------------------------------------------------------
    // receiver
    // -------------------------------------------------------------------------
    wire rx_mid  = tick & (rx_sub_r == `AST_TICK_MID);
    wire rx_end  = tick & (rx_sub_r == `AST_TICKS_BIT);
    wire rx_done = rx_st_r[4] & rx_end;
    wire pe_now  = par_on & (rx_x_r != par_bit(rx_sh_r, cfg_a_r[`AST_A_PAR_ODD]));
    wire fe_now  = ~rx_in;
    wire ovr_now = rda_r & ~rd_data;

    // -------------------------------------------------------------------------
    // interrupts: set wins over a clear in the same cycle
    // -------------------------------------------------------------------------
    reg [2:0] irq_set;
    always @* begin
        irq_set = 3'b000;
        irq_set[`AST_I_TX]  = tx_en & ~tdr_full_r;
        irq_set[`AST_I_RX]  = (rx_done & ~cfg_b_r[`AST_B_RX_IRQ_MSK]) |
                              (tick & ~rx_en & live_read);
        irq_set[`AST_I_ERR] = rx_done & (fe_now | pe_now | ovr_now);
    end
    wire [2:0] irq_clr = (wr & (paddr == `AST_OFS_IRQ_CLR)) ? pwdata[2:0] : 3'b000;
    assign irq = |(irq_stat_r & irq_en_r);

    // -------------------------------------------------------------------------
    // read mux, registered in the setup cycle
    // -------------------------------------------------------------------------
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (paddr)
            `AST_OFS_DATA:     rd_nxt[7:0] = rdr_r;
            `AST_OFS_STATUS:   rd_nxt[7:0] = {cts_s2_r, mark_rx_r, ovr_r, pe_r, fe_r,
                                              tx_st_r[0] & ~tdr_full_r, ~tdr_full_r,
                                              rda_r};
            `AST_OFS_CONFIG_A: rd_nxt[7:0] = cfg_a_r;
            `AST_OFS_CONFIG_B: rd_nxt[7:0] = cfg_b_r;
            `AST_OFS_BAUD_HI:  rd_nxt[7:0] = baud_view[15:8];
            `AST_OFS_BAUD_LO:  rd_nxt[7:0] = baud_view[7:0];
            `AST_OFS_IRQ_STAT: rd_nxt[2:0] = irq_stat_r;
            `AST_OFS_IRQ_EN:   rd_nxt[2:0] = irq_en_r;
            default:           rd_nxt = 32'h0000_0000;
        endcase
    end

    // -------------------------------------------------------------------------
    // control registers and apb
    // -------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata     <= 32'h0000_0000;
            cfg_a_r    <= `AST_RST_CFG;
            cfg_b_r    <= `AST_RST_CFG;
            baud_hi_r  <= `AST_RST_BAUD_BYTE;
            baud_lo_r  <= `AST_RST_BAUD_BYTE;
            brg_cnt_r  <= `AST_RST_BAUD;
            irq_stat_r <= 3'b000;
            irq_en_r   <= 3'b000;
            tdr_r      <= 8'h00;
            tdr_full_r <= 1'b0;
            rxd_s1_r   <= 1'b1;
            rxd_s2_r   <= 1'b1;
            cts_s1_r   <= 1'b0;
            cts_s2_r   <= 1'b0;
            ir_cnt_r   <= 5'h00;
        end else begin
            if (setup) begin
                prdata <= rd_nxt;
            end
            if (wr) begin
                case (paddr)
                    `AST_OFS_CONFIG_A: cfg_a_r   <= pwdata[7:0];
                    `AST_OFS_CONFIG_B: cfg_b_r   <= pwdata[7:0];
                    `AST_OFS_BAUD_HI:  baud_hi_r <= pwdata[7:0];
                    `AST_OFS_BAUD_LO:  baud_lo_r <= pwdata[7:0];
                    `AST_OFS_IRQ_EN:   irq_en_r  <= pwdata[2:0];
                    default:           irq_en_r  <= irq_en_r;
                endcase
            end
            brg_cnt_r  <= brg_nxt;
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            // a byte written while the holding register is full is dropped
            if (wr & (paddr == `AST_OFS_DATA) & ~tdr_full_r) begin
                tdr_r      <= pwdata[7:0];
                tdr_full_r <= 1'b1;
            end else if (tx_load) begin
                tdr_full_r <= 1'b0;
            end
            rxd_s1_r <= rxd;
            rxd_s2_r <= rxd_s1_r;
            cts_s1_r <= cts_n;
            cts_s2_r <= cts_s1_r;
            if (rxd_s2_r) begin
                ir_cnt_r <= `AST_IR_HOLD;
            end else if (tick && ir_cnt_r != 5'h00) begin
                ir_cnt_r <= ir_cnt_r - 5'h01;
            end
        end
    end

    // -------------------------------------------------------------------------
    // transmit state machine
    // -------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_r  <= ST_IDLE;
            tx_sub_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_sh_r  <= 8'h00;
            tx_x_r   <= 1'b1;
            txd      <= 1'b1;
        end else begin
            txd <= infrared ? ir_out : tx_line;
            if (tick && !tx_st_r[0]) begin
                tx_sub_r <= tx_sub_r + 4'h1;
            end
            case (tx_st_r)
                ST_IDLE: begin
                    if (tx_load) begin
                        tx_sh_r  <= tdr_r;
                        tx_x_r   <= multi ? cfg_b_r[`AST_B_MARKER_TX] :
                                    par_bit(tdr_r, cfg_a_r[`AST_A_PAR_ODD]);
                        tx_sub_r <= 4'h0;
                        tx_st_r  <= ST_START;
                    end
                end
                ST_START: begin
                    if (tx_end) begin
                        tx_bit_r <= 3'h0;
                        tx_st_r  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_end) begin
                        tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == 3'h7) begin
                            tx_st_r <= extra_on ? ST_EXTRA : ST_STOP;
                        end
                    end
                end
                ST_EXTRA: begin
                    if (tx_end) begin
                        tx_st_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_end) begin
                        tx_st_r <= ST_IDLE;
                    end
                end
                default: tx_st_r <= ST_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // receive state machine, samples each bit at its middle
    // -------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_r   <= ST_IDLE;
            rx_sub_r  <= 4'h0;
            rx_bit_r  <= 3'h0;
            rx_sh_r   <= 8'h00;
            rx_x_r    <= 1'b0;
            rdr_r     <= 8'h00;
            rda_r     <= 1'b0;
            fe_r      <= 1'b0;
            pe_r      <= 1'b0;
            ovr_r     <= 1'b0;
            mark_rx_r <= 1'b0;
        end else begin
            if (rx_done) begin
                rdr_r     <= rx_sh_r;
                rda_r     <= 1'b1;
                fe_r      <= fe_now;
                pe_r      <= pe_now;
                ovr_r     <= ovr_now;
                mark_rx_r <= multi & rx_x_r;
            end else if (rd_data) begin
                rda_r <= 1'b0;
                ovr_r <= 1'b0;
            end
            if (tick && !rx_st_r[0]) begin
                rx_sub_r <= rx_sub_r + 4'h1;
            end
            if (!rx_en) begin
                rx_st_r <= ST_IDLE;
            end else begin
                case (rx_st_r)
                    ST_IDLE: begin
                        if (!rx_in) begin
                            rx_sub_r <= 4'h0;
                            rx_st_r  <= ST_START;
                        end
                    end
                    ST_START: begin
                        // re-centre on the middle of the start bit, reject glitches
                        if (rx_mid) begin
                            rx_sub_r <= 4'h0;
                            rx_bit_r <= 3'h0;
                            rx_st_r  <= rx_in ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (rx_end) begin
                            rx_sh_r  <= {rx_in, rx_sh_r[7:1]};
                            rx_bit_r <= rx_bit_r + 3'h1;
                            if (rx_bit_r == 3'h7) begin
                                rx_st_r <= extra_on ? ST_EXTRA : ST_STOP;
                            end
                        end
                    end
                    ST_EXTRA: begin
                        if (rx_end) begin
                            rx_x_r  <= rx_in;
                            rx_st_r <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (rx_end) begin
                            rx_st_r <= ST_IDLE;
                        end
                    end
                    default: rx_st_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // ast_uart
`default_nettype wire

// ### logic/ast_consts.vh
// constants, register map and field positions of the serial transceiver
`ifndef AST_CONSTS_VH
`define AST_CONSTS_VH
// -------------------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------------------
`define AST_OFS_DATA     12'h000
`define AST_OFS_STATUS   12'h004
`define AST_OFS_CONFIG_A 12'h008
`define AST_OFS_CONFIG_B 12'h00C
`define AST_OFS_BAUD_HI  12'h010
`define AST_OFS_BAUD_LO  12'h014
`define AST_OFS_IRQ_STAT 12'h018
`define AST_OFS_IRQ_CLR  12'h01C
`define AST_OFS_IRQ_EN   12'h020
// -------------------------------------------------------------------------
// config a fields
// -------------------------------------------------------------------------
`define AST_A_TX_EN      7
`define AST_A_RX_EN      6
`define AST_A_CTS_GATE   5
`define AST_A_PAR_EN     4
`define AST_A_PAR_ODD    3
// -------------------------------------------------------------------------
// config b fields
// -------------------------------------------------------------------------
`define AST_B_MULTIDROP  7
`define AST_B_MARKER_TX  6
`define AST_B_BAUD_CTL   2
`define AST_B_RX_IRQ_MSK 1
`define AST_B_INFRARED   0
// -------------------------------------------------------------------------
// status fields
// -------------------------------------------------------------------------
`define AST_S_RX_AVAIL   0
`define AST_S_TX_EMPTY   1
`define AST_S_TX_IDLE    2
`define AST_S_FRAME_ERR  3
`define AST_S_PAR_ERR    4
`define AST_S_OVERRUN    5
`define AST_S_MARKER_RX  6
`define AST_S_CTS        7
// -------------------------------------------------------------------------
// interrupt bits, reset values and bit timing
// -------------------------------------------------------------------------
`define AST_I_TX         0
`define AST_I_RX         1
`define AST_I_ERR        2
`define AST_RST_CFG      8'h00
`define AST_RST_BAUD     16'h0000
`define AST_RST_BAUD_BYTE 8'h00
`define AST_TICKS_BIT    4'hF
`define AST_TICK_MID     4'h7
`define AST_IR_PULSE     4'h3
`define AST_IR_HOLD      5'h10
`endif

// ### tb/ast_uart_chk.sv
// port assertions for the serial transceiver
`default_nettype none
`include "ast_consts.vh"
module ast_uart_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        rxd,
    input wire logic        cts_n,
    input wire logic        txd,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    // misaligned offsets are refused just like those past the map
    wire logic bad = paddr > `AST_OFS_IRQ_EN || paddr[1:0] != 2'b00;
    wire logic en_off = acc && pwrite && paddr == `AST_OFS_IRQ_EN && pwdata[2:0] == 3'h0;
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    property p_err; acc && bad |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok; acc && !bad |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_rd0; acc && !pwrite && bad |-> prdata == 32'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
    property p_hold; acc |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved early");
    property p_irq_off; en_off |=> !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq high with all disabled");
    property p_start; $fell(txd) |-> !txd [*8]; endproperty
    a_start: assert property (p_start) else $error("low bit too short");
    property p_rst_irq; $rose(presetn) |-> !irq; endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("irq high after reset");
    c_err: cover property (acc && bad);
    c_frame: cover property ($fell(txd) ##1 !txd);
    c_irq: cover property ($rose(irq));
endmodule // ast_uart_chk
bind ast_uart ast_uart_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .rxd(rxd), .cts_n(cts_n), .txd(txd), .irq(irq)
);
`default_nettype wire

// ### tb/ast_remote.sv
// remote serial transceiver model: drives rxd and cts_n, decodes txd
`default_nettype none
module ast_remote #(
    parameter int BIT_CYC = 32
) (
    input  wire logic pclk,
    input  wire logic txd,
    output var  logic rxd,
    output var  logic cts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        extra_on = 1'b0;
    logic        ok;
    logic [8:0]  got;
    logic [10:0] fr;
    int          frames = 0;
    int          n;
    initial rxd = 1'b1;
    initial cts_n = 1'b1;
    // samples mid-bit, so a wrong bit time shows up as a corrupt byte
    always begin
        @(negedge txd);
        n = 10 + int'(extra_on);
        repeat (BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            fr[i] = txd;
            if (i < n - 1)
                repeat (BIT_CYC) @(posedge pclk);
        end
        got = extra_on ? fr[9:1] : {1'b0, fr[8:1]};
        ok = !fr[0] && fr[n - 1];
        frames++;
    end
    task automatic send(input logic [7:0] d, input logic xo, input logic x, input logic s);
        logic [10:0] b;
        b = xo ? {s, x, d, 1'b0} : {1'b1, s, d, 1'b0};
        for (int i = 0; i < 10 + int'(xo); i++) begin
            @(posedge pclk);
            rxd <= b[i];
            repeat (BIT_CYC - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rxd <= 1'b1;
    endtask
endmodule // ast_remote
`default_nettype wire

// ### tb/ast_uart_tb.sv
// self-checking bench for the serial transceiver
`default_nettype none
`include "ast_consts.vh"
module ast_uart_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CYC = 32; // reload 1: 16 ticks of 2 pclk cycles
    typedef struct packed {
        logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic err;
    } ast_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, txd, rxd, cts_n, irq, er;
    logic [31:0] rd;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          f;
    ast_row_t rows [10] = '{
        '{1'b0, `AST_OFS_CONFIG_A, 8'h00, 8'h00, 1'b0}, '{1'b0, `AST_OFS_CONFIG_B, 8'h00, 8'h00, 1'b0},
        '{1'b0, `AST_OFS_BAUD_HI, 8'h00, 8'h00, 1'b0}, '{1'b0, `AST_OFS_BAUD_LO, 8'h00, 8'h00, 1'b0},
        '{1'b0, `AST_OFS_IRQ_EN, 8'h00, 8'h00, 1'b0}, '{1'b1, `AST_OFS_BAUD_HI, 8'h12, 8'h12, 1'b0},
        '{1'b1, `AST_OFS_BAUD_LO, 8'h34, 8'h34, 1'b0}, '{1'b1, `AST_OFS_IRQ_EN, 8'h07, 8'h07, 1'b0},
        '{1'b1, 12'h024, 8'h55, 8'h00, 1'b1}, '{1'b1, `AST_OFS_CONFIG_B, 8'h84, 8'h84, 1'b0}};
    logic [7:0] xa [5] = '{8'h80, 8'h90, 8'h98, 8'h90, 8'h98};
    logic [7:0] xb [5] = '{8'h00, 8'h00, 8'h00, 8'hC0, 8'h80};
    logic [7:0] xd [5] = '{8'hA5, 8'h07, 8'h07, 8'h33, 8'h33};
    logic       xe [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    ast_uart uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .rxd(rxd), .cts_n(cts_n), .txd(txd), .irq(irq));
    ast_remote #(.BIT_CYC(BIT_CYC)) rm (.pclk(pclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
    always #12.5 pclk = ~pclk;
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk(32'h0, 32'h1);
            results();
        end
    endtask
    task automatic poll(input logic [11:0] a, input int b);
        // stale data from an earlier read must not end the poll before it starts
        rd = 32'h0;
        for (int n = 0; n < 2000 && rd[b] !== 1'b1; n++)
            apb(1'b0, a, 32'h0);
        if (rd[b] !== 1'b1) begin
            chk(rd, 32'hFFFF_FFFF);
            results();
        end
    endtask
    task automatic wait_frame(input int prev);
        for (int n = 0; n < 40 * BIT_CYC && rm.frames == prev; n++)
            @(posedge pclk);
        if (rm.frames == prev) begin
            chk(32'h0, 32'h1);
            results();
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        chk(txd, 1'b1);
        chk(irq, 1'b0);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w)
                apb(1'b1, rows[i].a, {24'h0, rows[i].d});
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, {24'h0, rows[i].e});
            chk(er, rows[i].err);
        end
        // baud control is set and the count runs down from 0x1200: live high byte
        apb(1'b0, `AST_OFS_BAUD_HI, 32'h0);
        chk(rd, 32'h11);
        apb(1'b1, `AST_OFS_BAUD_HI, 32'h0);
        apb(1'b1, `AST_OFS_BAUD_LO, 32'h1);
        // the old reload must run down before the new one is used
        repeat (5000) @(posedge pclk);
        apb(1'b1, `AST_OFS_IRQ_CLR, 32'h7);
        rd = 32'h0;
        poll(`AST_OFS_IRQ_STAT, 1);
        chk(irq, 1'b1);
        apb(1'b1, `AST_OFS_CONFIG_A, 32'h40);
        apb(1'b1, `AST_OFS_IRQ_CLR, 32'h7);
        repeat (8) @(posedge pclk);
        apb(1'b0, `AST_OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `AST_OFS_CONFIG_B, 32'h0);
        apb(1'b0, `AST_OFS_BAUD_LO, 32'h0);
        chk(rd, 32'h1);
        rm.send(8'h5A, 1'b0, 1'b0, 1'b1);
        poll(`AST_OFS_STATUS, 0);
        apb(1'b0, `AST_OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, `AST_OFS_DATA, 32'h0);
        chk(rd, 32'h5A);
        apb(1'b0, `AST_OFS_STATUS, 32'h0);
        chk(rd[0], 1'b0);
        apb(1'b1, `AST_OFS_CONFIG_B, 32'h2);
        apb(1'b1, `AST_OFS_IRQ_CLR, 32'h7);
        rm.send(8'h11, 1'b0, 1'b0, 1'b1);
        poll(`AST_OFS_STATUS, 0);
        apb(1'b0, `AST_OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h0);
        rm.send(8'h22, 1'b0, 1'b0, 1'b0);
        poll(`AST_OFS_IRQ_STAT, 2);
        chk(irq, 1'b1);
        apb(1'b1, `AST_OFS_CONFIG_A, 32'h0);
        apb(1'b1, `AST_OFS_IRQ_CLR, 32'h7);
        apb(1'b0, `AST_OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 5; i++) begin
            rm.extra_on = (i != 0);
            apb(1'b1, `AST_OFS_CONFIG_A, {24'h0, xa[i]});
            apb(1'b1, `AST_OFS_CONFIG_B, {24'h0, xb[i]});
            apb(1'b0, `AST_OFS_IRQ_STAT, 32'h0);
            chk(rd[0], 1'b1);
            f = rm.frames;
            apb(1'b1, `AST_OFS_DATA, {24'h0, xd[i]});
            apb(1'b1, `AST_OFS_IRQ_CLR, 32'h1);
            wait_frame(f);
            chk({23'h0, rm.got}, {23'h0, xe[i], xd[i]});
            chk(rm.ok, 1'b1);
        end
        rm.extra_on = 1'b0;
        apb(1'b1, `AST_OFS_CONFIG_B, 32'h0);
        apb(1'b1, `AST_OFS_CONFIG_A, 32'h0);
        f = rm.frames;
        apb(1'b1, `AST_OFS_DATA, 32'h3C);
        repeat (20 * BIT_CYC) @(posedge pclk);
        chk(rm.frames, f);
        apb(1'b1, `AST_OFS_CONFIG_A, 32'hA0);
        repeat (20 * BIT_CYC) @(posedge pclk);
        chk(rm.frames, f);
        rm.cts_n <= 1'b0;
        wait_frame(f);
        chk({23'h0, rm.got}, 32'h3C);
        rm.cts_n <= 1'b1;
        apb(1'b1, `AST_OFS_CONFIG_A, 32'h80);
        f = rm.frames;
        apb(1'b1, `AST_OFS_DATA, 32'hC3);
        wait_frame(f);
        chk({23'h0, rm.got}, 32'hC3);
        chk(irq, 1'b1);
        apb(1'b1, `AST_OFS_IRQ_EN, 32'h0);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, `AST_OFS_CONFIG_A, 32'h0);
        apb(1'b1, `AST_OFS_CONFIG_B, 32'h1);
        repeat (4) @(posedge pclk);
        chk(txd, 1'b0);
        results();
    end
endmodule // ast_uart_tb
`default_nettype wire
